// ---- src/wdog_pkg.sv ----
// Constants, register map and field layout of the watchdog.
// Assumes a single 250 MHz clock and a 32.768 kHz oscillator pin.
package wdog_pkg;
	// ======================================================
	// Register offsets
	localparam logic [7:0]  OFS_RELOAD  = 8'h00;
	localparam logic [7:0]  OFS_COUNT   = 8'h04;
	localparam logic [7:0]  OFS_CONTROL = 8'h08;
	localparam logic [7:0]  OFS_SERVICE = 8'h0c;
	localparam logic [7:0]  OFS_STATUS  = 8'h18;
	// ======================================================
	// Reset values and fixed numbers
	localparam logic [15:0] RST_RELOAD  = 16'h0400;
	localparam logic [15:0] RST_COUNT   = 16'h1000;
	localparam logic [15:0] RST_CONTROL = 16'h00e9;
	localparam logic [15:0] RST_STATUS  = 16'h0020;
	localparam logic [15:0] FIXED_LOAD  = 16'h1000;
	localparam logic [15:0] SERVICE_KEY = 16'hcccc;
	// ======================================================
	// Control fields
	localparam int CTL_FREEZE  = 0;
	localparam int CTL_IRQSEL  = 1;
	localparam int CTL_PRE_LO  = 2;
	localparam int CTL_ENABLE  = 5;
	localparam int CTL_PERIOD  = 6;
	localparam int CTL_RSVD_HI = 7;
	// ======================================================
	// Status fields
	localparam int STA_IRQ     = 0;
	localparam int STA_SVC     = 1;
	localparam int STA_LOAD    = 2;
	localparam int STA_CTL     = 3;
	localparam int STA_LOCK    = 4;
	// ======================================================
	// Prescaler selection
	typedef enum logic [1:0] {
		DIV_1    = 2'b00,
		DIV_16   = 2'b01,
		DIV_256  = 2'b10,
		DIV_4096 = 2'b11
	} prescale_t;
	localparam logic [11:0] TOP_DIV_1    = 12'h000;
	localparam logic [11:0] TOP_DIV_16   = 12'h00f;
	localparam logic [11:0] TOP_DIV_256  = 12'h0ff;
	localparam logic [11:0] TOP_DIV_4096 = 12'hfff;
	// Oscillator rate for reference
	localparam int OSC_FREQ_HZ = 32768;
endpackage : wdog_pkg

// ---- src/tick_if.sv ----
// Carries oscillator ticks between the watchdog and its prescaler.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface tick_if;
	import wdog_pkg::*;
	logic      osc_edge;
	logic      step;
	prescale_t sel;
	logic      clear;
	modport pre (output osc_edge, output step, input sel, input clear);
	modport core (input osc_edge, input step, output sel, output clear);
endinterface : tick_if

// ---- src/wdog_prescaler.sv ----
// Oscillator synchroniser and divide-by prescaler.
// Assumes the oscillator pin is asynchronous to clock_i.
`timescale 1ns/1ps
module wdog_prescaler (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic rst_n_i,
	// Oscillator pin
	input  wire logic low_freq_osc_i,
	// Tick carrier
	tick_if.pre       tick
);
	import wdog_pkg::*;
	logic        sync1_reg;
	logic        sync2_reg;
	logic        last_reg;
	logic [11:0] div_reg;
	logic [11:0] top;
	logic        rise;
	// ======================================================
	// Two-stage synchroniser and edge detect
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			last_reg  <= 1'b0;
		end else begin
			sync1_reg <= low_freq_osc_i;
			sync2_reg <= sync1_reg;
			last_reg  <= sync2_reg;
		end
	end
	assign rise = sync2_reg & ~last_reg;
	assign tick.osc_edge = rise;
	// ======================================================
	// Divider
	always_comb begin
		case (tick.sel)
			DIV_1:    top = TOP_DIV_1;
			DIV_16:   top = TOP_DIV_16;
			DIV_256:  top = TOP_DIV_256;
			DIV_4096: top = TOP_DIV_4096;
			default:  top = TOP_DIV_256;
		endcase
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			div_reg <= 12'h000;
		end else if (tick.clear) begin
			div_reg <= 12'h000;
		end else if (rise) begin
			div_reg <= (div_reg >= top) ? 12'h000 : div_reg + 12'h001;
		end
	end
	assign tick.step = rise && (div_reg >= top);
endmodule : wdog_prescaler

// ---- src/lowfreq_watchdog_timer.sv ----
// Watchdog timer top: register port, sync emulation, counter, timeout.
// Assumes a plain register port on clock_i and async oscillator and halt pins.
`timescale 1ns/1ps
module lowfreq_watchdog_timer (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	// Register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Oscillator and core state
	input  wire logic        low_freq_osc_i,
	input  wire logic        core_halted_i,
	// Timeout outputs
	output logic             wdog_reset_o,
	output logic             wdog_irq_o
);
	import wdog_pkg::*;

	// ======================================================
	// Declarations
	tick_if tick ();
	logic [15:0] reload_value_reg;
	logic [15:0] control_reg;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic        run_reg;
	logic        lock_reg;
	logic        disabled_once_reg;
	logic        irq_pending_reg;
	logic        ctl_busy_reg;
	logic        load_busy_reg;
	logic        svc_busy_reg;
	logic [15:0] svc_data_reg;
	logic        halt_s1_reg;
	logic        halt_s2_reg;
	logic        wdog_reset_reg;
	logic [31:0] rdata_reg;
	logic        wr_ctl;
	logic        wr_load;
	logic        wr_svc;
	logic        ctl_accept;
	logic        disable_req;
	logic        refuse_disable;
	logic        apply_ctl;
	logic        apply_load;
	logic        apply_svc;
	logic        svc_good;
	logic        svc_bad;
	logic        frozen;
	logic        wrap;
	logic        timeout;
	logic [15:0] reload_pick;

	// ======================================================
	// Prescaler
	wdog_prescaler u_pre (
		.clock_i        (clock_i),
		.rst_n_i        (rst_n_i),
		.low_freq_osc_i (low_freq_osc_i),
		.tick           (tick.pre)
	);
	assign tick.sel   = prescale_t'(control_reg[CTL_PRE_LO +: 2]);
	assign tick.clear = apply_ctl | (apply_svc & svc_good);

	// ======================================================
	// Write decode
	assign wr_ctl  = wr_i && (addr_i == OFS_CONTROL);
	assign wr_load = wr_i && (addr_i == OFS_RELOAD) && !lock_reg;
	assign wr_svc  = wr_i && (addr_i == OFS_SERVICE);
	assign disable_req    = !wdata_i[CTL_ENABLE];
	// A disable while running is allowed only once
	assign refuse_disable = disable_req && run_reg && disabled_once_reg;
	assign ctl_accept     = wr_ctl && !lock_reg && !refuse_disable;

	// ======================================================
	// Halt pin synchroniser
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			halt_s1_reg <= 1'b0;
			halt_s2_reg <= 1'b0;
		end else begin
			halt_s1_reg <= core_halted_i;
			halt_s2_reg <= halt_s1_reg;
		end
	end

	// ======================================================
	// Reload register
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			reload_value_reg <= RST_RELOAD;
		end else if (wr_load) begin
			reload_value_reg <= wdata_i[15:0];
		end
	end

	// ======================================================
	// Control register
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			control_reg <= RST_CONTROL;
		end else if (ctl_accept) begin
			control_reg <= {8'h00, control_reg[CTL_RSVD_HI], wdata_i[6:5], 1'b0, wdata_i[3:0]};
		end
	end

	// ======================================================
	// Lock and disable history
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			lock_reg          <= 1'b0;
			disabled_once_reg <= 1'b0;
		end else if (ctl_accept) begin
			if (wdata_i[CTL_ENABLE]) begin
				lock_reg <= 1'b1;
			end
			if (disable_req) begin
				disabled_once_reg <= 1'b1;
			end
		end
	end

	// ======================================================
	// Sync-in-progress flags, cleared on the next oscillator edge
	assign apply_ctl  = ctl_busy_reg && tick.osc_edge;
	assign apply_load = load_busy_reg && tick.osc_edge;
	assign apply_svc  = svc_busy_reg && tick.osc_edge;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ctl_busy_reg <= 1'b0;
		end else if (ctl_accept) begin
			ctl_busy_reg <= 1'b1;
		end else if (apply_ctl) begin
			ctl_busy_reg <= 1'b0;
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			load_busy_reg <= 1'b0;
		end else if (wr_load) begin
			load_busy_reg <= 1'b1;
		end else if (apply_load) begin
			load_busy_reg <= 1'b0;
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			svc_busy_reg <= 1'b0;
			svc_data_reg <= 16'h0000;
		end else if (wr_svc) begin
			svc_busy_reg <= 1'b1;
			svc_data_reg <= wdata_i[15:0];
		end else if (apply_svc) begin
			svc_busy_reg <= 1'b0;
		end
	end
	assign svc_good = (svc_data_reg == SERVICE_KEY);
	assign svc_bad  = !svc_good;

	// ======================================================
	// Run state in the oscillator timebase
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			run_reg <= RST_CONTROL[CTL_ENABLE];
		end else if (apply_ctl) begin
			run_reg <= control_reg[CTL_ENABLE];
		end
	end

	// ======================================================
	// Counter
	// Boot-loader mode has no input here: counting never stops for it
	assign reload_pick = control_reg[CTL_PERIOD] ? reload_value_reg : FIXED_LOAD;
	assign frozen = control_reg[CTL_FREEZE] && halt_s2_reg;
	assign wrap   = run_reg && !frozen && tick.step && (count_reg == 16'h0000);
	always_comb begin
		count_next = count_reg;
		if (apply_ctl) begin
			count_next = control_reg[CTL_ENABLE] ? reload_pick : RST_COUNT;
		end else if (apply_svc && svc_good) begin
			count_next = reload_pick;
		end else if (apply_load && control_reg[CTL_PERIOD]) begin
			count_next = reload_value_reg;
		end else if (wrap) begin
			count_next = reload_pick;
		end else if (run_reg && !frozen && tick.step) begin
			count_next = count_reg - 16'h0001;
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			count_reg <= RST_COUNT;
		end else begin
			count_reg <= count_next;
		end
	end

	// ======================================================
	// Timeout handling
	assign timeout = wrap || (apply_svc && svc_bad);
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			irq_pending_reg <= 1'b0;
		end else if (timeout && control_reg[CTL_IRQSEL]) begin
			irq_pending_reg <= 1'b1;
		end else if (apply_svc && svc_good) begin
			irq_pending_reg <= 1'b0;
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			wdog_reset_reg <= 1'b0;
		end else begin
			wdog_reset_reg <= timeout && !control_reg[CTL_IRQSEL];
		end
	end
	assign wdog_reset_o = wdog_reset_reg;
	assign wdog_irq_o   = irq_pending_reg;

	// ======================================================
	// Read port, data valid one cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rdata_reg <= 32'h0000_0000;
		end else if (rd_i) begin
			case (addr_i)
				OFS_RELOAD:  rdata_reg <= {16'h0000, reload_value_reg};
				OFS_COUNT:   rdata_reg <= {16'h0000, count_reg};
				OFS_CONTROL: rdata_reg <= {16'h0000, control_reg};
				OFS_SERVICE: rdata_reg <= 32'h0000_0000;
				OFS_STATUS:  rdata_reg <= {16'h0000, RST_STATUS[15:5], lock_reg, ctl_busy_reg,
					load_busy_reg, svc_busy_reg, irq_pending_reg};
				default:     rdata_reg <= 32'h0000_0000;
			endcase
		end else begin
			rdata_reg <= 32'h0000_0000;
		end
	end
	assign rdata_o = rdata_reg;
endmodule : lowfreq_watchdog_timer

// ---- sim/wdog_monitor.sv ----
// Port-level checker for the watchdog timer.
// Assumes it is bound to the watchdog top module.
`timescale 1ns/1ps
module wdog_monitor
	import wdog_pkg::*;
(
	// Clock and reset
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	// Register port
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	// Timeout outputs
	input wire logic        wdog_reset_o,
	input wire logic        wdog_irq_o
);
	// ==========================================
	// Assertions
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data not zero outside read cycle");
	AST_UPPER_ZERO: assert property (rdata_o[31:16] == 16'h0)
		else $error("upper read bits not zero");
	AST_SVC_READ_ZERO: assert property ($past(rd_i && addr_i == OFS_SERVICE) |-> rdata_o == 32'h0)
		else $error("service register read not zero");
	AST_IRQ_MIRROR: assert property ($past(rd_i && addr_i == OFS_STATUS) |-> rdata_o[0] == $past(wdog_irq_o))
		else $error("status pending flag differs from irq output");
	AST_RESET_PULSE: assert property (wdog_reset_o |=> !wdog_reset_o)
		else $error("reset request longer than one cycle");
	AST_IRQ_NOT_RESET: assert property (wdog_irq_o |-> !wdog_reset_o)
		else $error("reset request while interrupt pending");
	AST_BAD_KEY: assert property (wr_i && addr_i == OFS_SERVICE && wdata_i[15:0] != SERVICE_KEY
		|-> ##[1:24] (wdog_reset_o || wdog_irq_o)) else $error("wrong key gave no timeout");
	AST_KEY_CLEARS: assert property (wr_i && addr_i == OFS_SERVICE && wdata_i[15:0] == SERVICE_KEY
		|-> ##[1:24] !wdog_irq_o) else $error("service key left interrupt pending");
endmodule : wdog_monitor

bind lowfreq_watchdog_timer wdog_monitor i_mon (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wdog_reset_o(wdog_reset_o),
	.wdog_irq_o(wdog_irq_o));

// ---- sim/tb_lowfreq_watchdog_timer.sv ----
// Self-checking testbench for the watchdog timer.
// Assumes the oscillator pin may toggle every four clocks.
`timescale 1ns/1ps
module tb_lowfreq_watchdog_timer;
	import wdog_pkg::*;
	logic        clock_i, rst_n_i, wr_i, rd_i, low_freq_osc_i, core_halted_i, wdog_reset_o, wdog_irq_o;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i, rdata_o, v, a;
	logic [15:0] r;
	int          miscompares, tests_run, n, seed;
	int          cyc = 0;
	logic [7:0]  ra [6] = '{OFS_RELOAD, OFS_COUNT, OFS_CONTROL, OFS_STATUS, OFS_SERVICE, 8'h10};
	logic [31:0] re [6] = '{32'h400, 32'h1000, 32'he9, 32'h20, 32'h0, 32'h0};
	lowfreq_watchdog_timer i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .low_freq_osc_i(low_freq_osc_i),
		.core_halted_i(core_halted_i), .wdog_reset_o(wdog_reset_o), .wdog_irq_o(wdog_irq_o));
	// ==========================================
	// Clock, oscillator and timeout
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc[1:0] == 2'h3) low_freq_osc_i <= ~low_freq_osc_i;
		if (cyc == 90000) begin
			miscompares++;
			test_done;
		end
	end
	// ==========================================
	// Tasks
	task test_done;
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	// Expected control read-back: reserved bit 7 keeps its reset value, bit 4 reads zero
	function automatic logic [31:0] ctl_exp(input logic [31:0] w);
		return {24'h0, RST_CONTROL[CTL_RSVD_HI], w[6:5], 1'b0, w[3:0]};
	endfunction : ctl_exp
	// Expected cycles to a timeout: prescaled steps times divide ratio times eight clocks per oscillator period
	function automatic int tmo(input int steps, input int div);
		return steps * div * 8;
	endfunction : tmo
	task wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clock_i);
		addr_i  <= ad;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i    <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] ad);
		@(posedge clock_i);
		addr_i <= ad;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i   <= 1'b0;
		#1 v = rdata_o;
	endtask : rd
	task sync;
		for (int i = 0; i < 40; i++) begin
			rd(OFS_STATUS);
			if (v[3:1] === 3'h0) break;
		end
	endtask : sync
	task wait_out(input bit w, input int lim);
		n = 0;
		while (n < lim && (w ? wdog_irq_o : wdog_reset_o) !== 1'b1) begin
			@(posedge clock_i);
			#1;
			n++;
		end
	endtask : wait_out
	task rst_chk;
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		rst_n_i <= 1'b1;
		foreach (ra[i]) begin
			rd(ra[i]);
			chk(v, re[i]);
		end
	endtask : rst_chk
	// ==========================================
	// Scenarios
	initial begin
		seed = 32'h150f;
		{wr_i, rd_i, core_halted_i, low_freq_osc_i, rst_n_i} = 5'h0;
		addr_i = 8'h0;
		wdata_i = 32'h0;
		rst_chk;
		wr(OFS_COUNT, 32'h55);
		rd(OFS_COUNT);
		chk(v, 32'h1000);
		wr(OFS_RELOAD, 32'h200);
		sync;
		rd(OFS_COUNT);
		chk(v, 32'h200);
		wr(OFS_SERVICE, {16'h0, SERVICE_KEY});
		sync;
		repeat (3000) @(posedge clock_i);
		rd(OFS_COUNT);
		chk(v, 32'h1ff);
		wr(OFS_CONTROL, 32'h49);
		sync;
		rd(OFS_COUNT);
		chk(v, 32'h1000);
		for (int k = 0; k < 4; k++) begin
			wr(OFS_CONTROL, 32'h40 | (k << 2));
			rd(OFS_CONTROL);
			chk(v, ctl_exp(32'h40 | (k << 2)));
		end
		r = 16'h8 + 16'($unsigned($random(seed)) % 56);
		wr(OFS_RELOAD, {16'h0, r});
		wr(OFS_CONTROL, 32'h42);
		sync;
		rd(OFS_RELOAD);
		chk(v, {16'h0, r});
		wr(OFS_CONTROL, 32'h62);
		sync;
		rd(OFS_COUNT);
		chk(32'(v == r || v == r - 1), 1);
		rd(OFS_STATUS);
		chk(v & 32'h10, 32'h10);
		wr(OFS_CONTROL, 32'h49);
		wr(OFS_RELOAD, 32'h1234);
		rd(OFS_CONTROL);
		chk(v, ctl_exp(32'h62));
		rd(OFS_RELOAD);
		chk(v, {16'h0, r});
		wr(OFS_SERVICE, {16'h0, SERVICE_KEY});
		sync;
		wr(OFS_SERVICE, 32'h1234);
		wait_out(1'b1, 40);
		chk(32'(n < 40), 1);
		rd(OFS_STATUS);
		chk(v[0], 1);
		wr(OFS_SERVICE, {16'h0, SERVICE_KEY});
		sync;
		chk(wdog_irq_o, 0);
		wait_out(1'b1, 1000);
		chk(32'(n >= r * 8 && n <= r * 8 + 24), 1);
		core_halted_i <= 1'b1;
		rd(OFS_COUNT);
		a = v;
		repeat (40) @(posedge clock_i);
		rd(OFS_COUNT);
		chk(32'(v != a), 1);
		core_halted_i <= 1'b0;
		$display("test unlocked and interrupt mode done");
		rst_chk;
		wr(OFS_CONTROL, 32'h21);
		sync;
		rd(OFS_COUNT);
		chk(32'(v == 32'h1000 || v == 32'hfff), 1);
		core_halted_i <= 1'b1;
		repeat (10) @(posedge clock_i);
		rd(OFS_COUNT);
		a = v;
		repeat (80) @(posedge clock_i);
		rd(OFS_COUNT);
		chk(v, a);
		core_halted_i <= 1'b0;
		repeat (40) @(posedge clock_i);
		rd(OFS_COUNT);
		chk(32'(v < a), 1);
		wr(OFS_SERVICE, 32'h0);
		wait_out(1'b0, 40);
		chk(32'(n < 40), 1);
		chk(wdog_irq_o, 0);
		wr(OFS_SERVICE, {16'h0, SERVICE_KEY});
		sync;
		wait_out(1'b0, 34000);
		chk(32'(n > 32700 && n < 32850), 1);
		rd(OFS_COUNT);
		chk(32'(v == 32'h1000 || v == 32'hfff), 1);
		$display("test fixed and reset mode done");
		rst_chk;
		wr(OFS_CONTROL, 32'h44);
		wr(OFS_RELOAD, {16'h0, r});
		sync;
		wr(OFS_CONTROL, 32'h64);
		sync;
		rd(OFS_CONTROL);
		chk(v, ctl_exp(32'h64));
		wait_out(1'b0, 9000);
		chk(32'(n >= tmo(r + 1, 16) - 24 && n <= tmo(r + 1, 16)), 1);
		$display("test divide by sixteen done");
		test_done;
	end
endmodule : tb_lowfreq_watchdog_timer
